//--- logic/fifo_flag_consts.vh
// constants of the fifo flag block: register map, fields, reset values
`ifndef FIFO_FLAG_CONSTS_VH
`define FIFO_FLAG_CONSTS_VH

// register byte offsets
`define OFS_CTRL          12'h000
`define OFS_NEAR_FULL     12'h004
`define OFS_NEAR_EMPTY    12'h008
`define OFS_STATUS        12'h00c
`define OFS_INT_STAT      12'h010
`define OFS_INT_MASK      12'h014

// control register fields
`define CTRL_WR_CODE_LSB  0
`define CTRL_RD_CODE_LSB  4
`define CTRL_FLUSH_BIT    8

// status register fields
`define ST_EMPTY_BIT      0
`define ST_FULL_BIT       1
`define ST_NEAR_EMPTY_BIT 2
`define ST_NEAR_FULL_BIT  3
`define ST_LEVEL_LSB      16

// interrupt event bits
`define EV_FULL           0
`define EV_EMPTY          1
`define EV_NEAR_FULL      2
`define EV_NEAR_EMPTY     3
`define EV_OVERFLOW       4
`define EV_UNDERFLOW      5
`define EV_COUNT          6

// port width codes
`define WCODE_1           3'h0
`define WCODE_2           3'h1
`define WCODE_4           3'h2
`define WCODE_8           3'h3
`define WCODE_9           3'h4
`define WCODE_18          3'h5

// storage size in address units and counter width
`define FIFO_UNITS        13'h1000
`define LEVEL_W           13
`define THR_W             12

// reset values
`define RST_WR_CODE       3'h0
`define RST_RD_CODE       3'h0
`define RST_NEAR_FULL     12'hf00
`define RST_NEAR_EMPTY    12'h100
`define RST_INT_MASK      6'h00

`endif

//--- logic/fifo_flag_top.v
// fifo flag block: apb registers, interrupt and flag tracking
//
// Contract
// [R1] near-empty rises when a read brings the address difference down to its threshold.
// [R2] near-empty stays up until the difference climbs above its threshold.
// [R3] with unequal port widths the near-full threshold counts write-width entries; the code compares it with the address-unit difference instead.
// [R4] thresholds are 12 bits; 9 and 18 bit words are scaled by 8 and 16.
// [R5] full rises when a whole write word no longer fits, empty when no whole read word.
// [R6] wide reads see empty until narrow writes have built one whole read word.
// [R7] wide writes see full until narrow reads have freed one whole write word.
// [R8] near-full rises at its threshold and falls when the difference drops below it.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "fifo_flag_consts.vh"
module fifo_flag_top (
  // clock and reset
  input  wire                  clk_sys,
  input  wire                  resetn,
  // apb slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [11:0]           paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata,
  output reg                   pready,
  output reg                   pslverr,
  // user fifo ports
  input  wire                  wr_en,
  input  wire                  rd_en,
  // flags
  output wire                  full,
  output wire                  empty,
  output wire                  near_full_flag,
  output wire                  near_empty_flag,
  output wire [`LEVEL_W-1:0]   level,
  // interrupt
  output reg                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // address units taken by one word of a port; 9 and 18 bit words use 8 and 16
  function [`LEVEL_W-1:0] word_units;
    input [2:0] code;
    begin
      case (code)
        `WCODE_1:  word_units = 13'h0001;
        `WCODE_2:  word_units = 13'h0002;
        `WCODE_4:  word_units = 13'h0004;
        `WCODE_8:  word_units = 13'h0008;
        `WCODE_9:  word_units = 13'h0008; // R4
        `WCODE_18: word_units = 13'h0010; // R4
        default:   word_units = 13'h0001;
      endcase
    end
  endfunction

  // true when the offset is one of the mapped registers
  function mapped;
    input [11:0] ofs;
    begin
      mapped = (ofs == `OFS_CTRL) || (ofs == `OFS_NEAR_FULL) ||
               (ofs == `OFS_NEAR_EMPTY) || (ofs == `OFS_STATUS) ||
               (ofs == `OFS_INT_STAT) || (ofs == `OFS_INT_MASK);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg  [2:0]            wr_code;
  reg  [2:0]            rd_code;
  reg                   flush;
  reg  [`THR_W-1:0]     near_full_threshold;
  reg  [`THR_W-1:0]     near_empty_threshold;
  reg  [`EV_COUNT-1:0]  int_stat;
  reg  [`EV_COUNT-1:0]  int_mask;
  reg                   full_d;
  reg                   empty_d;
  reg                   near_full_d;
  reg                   near_empty_d;
  reg  [31:0]           next_prdata;
  wire                  setup_phase;
  wire                  wr_commit;
  wire [`EV_COUNT-1:0]  events;
  wire [`EV_COUNT-1:0]  w1c;
  wire [`EV_COUNT-1:0]  next_int_stat;
  wire [`LEVEL_W-1:0]   wr_units;
  wire [`LEVEL_W-1:0]   rd_units;

  assign setup_phase = psel & ~penable;
  assign wr_commit   = psel & penable & pready & pwrite & ~pslverr;
  assign wr_units    = word_units(wr_code);
  assign rd_units    = word_units(rd_code);

  ////////////////////////////////////////////////////////////////////////////
  // flag tracking

  fifo_level_track u_track (
    .clk_sys              (clk_sys),
    .resetn               (resetn),
    .flush                (flush),
    .wr_units             (wr_units),
    .rd_units             (rd_units),
    .near_full_threshold  (near_full_threshold),
    .near_empty_threshold (near_empty_threshold),
    .wr_en                (wr_en),
    .rd_en                (rd_en),
    .full                 (full),
    .empty                (empty),
    .near_full_flag       (near_full_flag),
    .near_empty_flag      (near_empty_flag),
    .level                (level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait-free access phase, error on unmapped offsets

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~mapped(paddr);
      prdata  <= setup_phase ? next_prdata : 32'h0000_0000;
    end
  end

  // read data mux, reserved bits read zero
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: begin
        next_prdata[`CTRL_WR_CODE_LSB +: 3] = wr_code;
        next_prdata[`CTRL_RD_CODE_LSB +: 3] = rd_code;
      end
      `OFS_NEAR_FULL: begin
        next_prdata[`THR_W-1:0] = near_full_threshold;
      end
      `OFS_NEAR_EMPTY: begin
        next_prdata[`THR_W-1:0] = near_empty_threshold;
      end
      `OFS_STATUS: begin
        next_prdata[`ST_EMPTY_BIT]              = empty;
        next_prdata[`ST_FULL_BIT]               = full;
        next_prdata[`ST_NEAR_EMPTY_BIT]         = near_empty_flag;
        next_prdata[`ST_NEAR_FULL_BIT]          = near_full_flag;
        next_prdata[`ST_LEVEL_LSB +: `LEVEL_W] = level;
      end
      `OFS_INT_STAT: begin
        next_prdata[`EV_COUNT-1:0] = int_stat;
      end
      `OFS_INT_MASK: begin
        next_prdata[`EV_COUNT-1:0] = int_mask;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // writable registers; flush is a one-cycle pulse

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_code              <= `RST_WR_CODE;
      rd_code              <= `RST_RD_CODE;
      flush                <= 1'b0;
      near_full_threshold  <= `RST_NEAR_FULL;
      near_empty_threshold <= `RST_NEAR_EMPTY;
      int_mask             <= `RST_INT_MASK;
    end else begin
      flush <= 1'b0;
      if (wr_commit) begin
        case (paddr)
          `OFS_CTRL: begin
            wr_code <= pwdata[`CTRL_WR_CODE_LSB +: 3];
            rd_code <= pwdata[`CTRL_RD_CODE_LSB +: 3];
            flush   <= pwdata[`CTRL_FLUSH_BIT];
          end
          `OFS_NEAR_FULL: begin
            near_full_threshold <= pwdata[`THR_W-1:0]; // R3 R4
          end
          `OFS_NEAR_EMPTY: begin
            near_empty_threshold <= pwdata[`THR_W-1:0]; // R4
          end
          `OFS_INT_MASK: begin
            int_mask <= pwdata[`EV_COUNT-1:0];
          end
          default: begin
            flush <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky events (flag rising edges, refused writes and reads), write one to clear, set wins

  assign events[`EV_FULL]       = full & ~full_d;
  assign events[`EV_EMPTY]      = empty & ~empty_d;
  assign events[`EV_NEAR_FULL]  = near_full_flag & ~near_full_d;
  assign events[`EV_NEAR_EMPTY] = near_empty_flag & ~near_empty_d;
  assign events[`EV_OVERFLOW]   = wr_en & full;  // refused write
  assign events[`EV_UNDERFLOW]  = rd_en & empty; // refused read

  assign w1c           = (wr_commit && paddr == `OFS_INT_STAT) ? pwdata[`EV_COUNT-1:0] : {`EV_COUNT{1'b0}};
  assign next_int_stat = (int_stat & ~w1c) | events;

  // edge history, status and the registered interrupt line
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      full_d       <= 1'b0;
      empty_d      <= 1'b1;
      near_full_d  <= 1'b0;
      near_empty_d <= 1'b1;
      int_stat     <= {`EV_COUNT{1'b0}};
      irq          <= 1'b0;
    end else begin
      full_d       <= full;
      empty_d      <= empty;
      near_full_d  <= near_full_flag;
      near_empty_d <= near_empty_flag;
      int_stat     <= next_int_stat;
      irq          <= |(next_int_stat & int_mask);
    end
  end

endmodule

//--- logic/fifo_level_track.v
// occupancy counter and flag generation for the fifo ports
`timescale 1ns/1ns
`include "fifo_flag_consts.vh"
module fifo_level_track (
  // clock and reset
  input  wire                  clk_sys,
  input  wire                  resetn,
  // configuration
  input  wire                  flush,
  input  wire [`LEVEL_W-1:0]   wr_units,
  input  wire [`LEVEL_W-1:0]   rd_units,
  input  wire [`THR_W-1:0]     near_full_threshold,
  input  wire [`THR_W-1:0]     near_empty_threshold,
  // user ports
  input  wire                  wr_en,
  input  wire                  rd_en,
  // flags and level
  output reg                   full,
  output reg                   empty,
  output reg                   near_full_flag,
  output reg                   near_empty_flag,
  output reg  [`LEVEL_W-1:0]   level
);

  reg  [`LEVEL_W-1:0] next_level;
  wire                wr_take;
  wire                rd_take;

  // a word moves only while its whole width fits or is present
  assign wr_take = wr_en & ~full;
  assign rd_take = rd_en & ~empty;

  // write-minus-read address difference after this cycle
  always @* begin
    next_level = level;
    if (flush) begin
      next_level = {`LEVEL_W{1'b0}};
    end else begin
      if (wr_take) begin
        next_level = next_level + wr_units;
      end
      if (rd_take) begin
        next_level = next_level - rd_units;
      end
    end
  end

  // flags follow the new difference each cycle
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      level           <= {`LEVEL_W{1'b0}};
      full            <= 1'b0;
      empty           <= 1'b1;
      near_full_flag  <= 1'b0;
      near_empty_flag <= 1'b1;
    end else begin
      level           <= next_level;
      full            <= (next_level + wr_units) > `FIFO_UNITS; // R5 R7
      empty           <= next_level < rd_units; // R5 R6
      near_full_flag  <= next_level >= {1'b0, near_full_threshold}; // R8; the threshold is compared in address units, not write-width entries (R3)
      near_empty_flag <= next_level <= {1'b0, near_empty_threshold}; // R1 R2
    end
  end

endmodule

//--- tb/fifo_flag_top_bench.sv
// self-checking bench of the fifo flag block
`timescale 1ns/1ns
module fifo_flag_top_bench;
  reg         clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg         want_wr = 0, want_rd = 0, slow = 0, cmp_on = 0, perr, e_full, e_empty, e_nf, e_ne;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, rdat;
  wire [31:0] prdata;
  wire        pready, pslverr, wr_en, rd_en, full, empty, near_full_flag, near_empty_flag, irq;
  wire [12:0] level;
  integer     num_errors = 0, n_tests = 0, cyc = 0, i, k, n;
  integer     lvl = 0, wu = 1, ru = 1, nft = 12'hf00, net = 12'h100;

  always #4 clk_sys = ~clk_sys;
  fifo_flag_top u_fifo_flag_top (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wr_en(wr_en), .rd_en(rd_en), .full(full), .empty(empty), .near_full_flag(near_full_flag),
    .near_empty_flag(near_empty_flag), .level(level), .irq(irq));
  fifo_user_model u_fifo_user_model (.clk_sys(clk_sys), .resetn(resetn), .want_wr(want_wr),
    .want_rd(want_rd), .slow(slow), .wr_en(wr_en), .rd_en(rd_en));
  //////////////////////////////////////////////////////////////////////////////
  // address units of a port width code; 9 and 18 bit words count as 8 and 16
  function integer units(input integer c);
    units = c == 1 ? 2 : c == 2 ? 4 : (c == 3 || c == 4) ? 8 : c == 5 ? 16 : 1;
  endfunction
  task automatic check(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // one apb transfer; waits for ready, then takes data and releases
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rdat = prdata;
      perr = pslverr;
      psel <= 0; penable <= 0;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // occupancy reference: compares last cycle's prediction, then steps it
  always @(posedge clk_sys) begin
    if (cmp_on) begin
      check(full, e_full);
      check(empty, e_empty);
      check(near_full_flag, e_nf);
      check(near_empty_flag, e_ne);
      check(level, lvl);
    end
    if (resetn) lvl = lvl + (wr_en && !e_full ? wu : 0) - (rd_en && !e_empty ? ru : 0);
    e_full = lvl + wu > 4096; e_empty = lvl < ru; e_nf = lvl >= nft; e_ne = lvl <= net;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  // reset, register defaults, one width pair, traffic, then interrupts
  task run_cfg(input integer wc, input integer rc, input integer thf, input integer the);
    begin
      @(posedge clk_sys);
      resetn <= 0; cmp_on <= 0; want_wr <= 0; want_rd <= 0;
      @(negedge clk_sys);
      lvl = 0; wu = 1; ru = 1; nft = 12'hf00; net = 12'h100;
      @(posedge clk_sys);
      resetn <= 1;
      for (k = 0; k < 7; k = k + 1) begin
        apb(0, 4 * k, 0);
        check(rdat, k == 1 ? 32'hf00 : k == 2 ? 32'h100 : k == 3 ? 32'h5 : 32'h0);
        check(perr, k == 6);
      end
      apb(1, 12'h000, rc * 16 + wc);
      apb(1, 12'h004, thf);
      apb(1, 12'h008, the);
      @(negedge clk_sys);
      wu = units(wc); ru = units(rc); nft = thf; net = the;
      repeat (2) @(posedge clk_sys);
      cmp_on <= 1;
      for (k = 0; k < 4; k = k + 1) begin
        n = k == 0 ? 4096 / wu + 64 : k == 2 ? 4096 / ru + 64 : 300;
        repeat (n) begin
          @(posedge clk_sys);
          want_wr <= k % 2 ? $urandom % 2 == 1 : k == 0;
          want_rd <= k % 2 ? $urandom % 2 == 1 : k == 2;
          slow <= k % 2 ? $urandom % 2 == 1 : 1'b0;
        end
      end
      want_wr <= 0; want_rd <= 0;
      repeat (4) @(posedge clk_sys);
      apb(0, 12'h010, 0);
      check(rdat, 32'h3f);
      apb(1, 12'h014, 32'h10);
      repeat (2) @(posedge clk_sys);
      check(irq, 1);
      apb(1, 12'h010, 32'h3f);
      repeat (2) @(posedge clk_sys);
      check(irq, 0);
      apb(0, 12'h010, 0);
      check(rdat, 0);
      // flush empties the store; the model follows once the flush edge has passed
      cmp_on <= 0;
      apb(1, 12'h000, rc * 16 + wc + 256);
      @(posedge clk_sys);
      @(negedge clk_sys);
      lvl = 0;
      @(posedge clk_sys);
      cmp_on <= 1;
      check(level, 0);
      apb(0, 12'h00c, 0);
      check(rdat, 32'h5);
      apb(0, 12'h000, 0);
      check(rdat, rc * 16 + wc);
      apb(1, 12'h018, 32'hffff_ffff);
      check(perr, 1);
    end
  endtask
  // main sequence: every width code once on each port
  initial begin
    void'($urandom(32'ha424));
    repeat (6) @(posedge clk_sys);
    resetn <= 1;
    for (i = 0; i < 6; i = i + 1) run_cfg(i, 5 - i, 1 + $urandom % 4000, 16 + $urandom % 2984);
    run_cfg(7, 6, 4095, 16);
    wrap_up;
  end
endmodule

//--- tb/fifo_flag_top_checker.sv
// assertions on the ports of the fifo flag block
`timescale 1ns/1ns
module fifo_flag_checker (
  // clock and reset
  input wire        clk_sys,
  input wire        resetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  // fifo
  input wire        wr_en,
  input wire        rd_en,
  input wire        full,
  input wire        empty,
  input wire        near_full_flag,
  input wire        near_empty_flag,
  input wire [12:0] level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  reg  [1:0] psel_h;
  wire       quiet;
  // select history, so that config writes stay out of the flag checks
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) psel_h <= 2'h0;
    else psel_h <= {psel_h[0], psel};
  end
  assign quiet = !psel && psel_h == 2'h0;
  a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready in access");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_empty_zero: assert property (level == 13'h0 |-> empty) else $error("empty low at zero");
  a_full_top: assert property (level == 13'h1000 |-> full) else $error("full low at top");
  a_no_overfill: assert property (full && wr_en && !rd_en && quiet |=> $stable(level))
    else $error("write taken while full");
  a_no_underrun: assert property (empty && rd_en && !wr_en && quiet |=> $stable(level))
    else $error("read taken while empty");
  a_near_e_hold: assert property (near_empty_flag && !wr_en && quiet |=> near_empty_flag)
    else $error("near empty dropped");
  a_near_f_hold: assert property (near_full_flag && !rd_en && quiet |=> near_full_flag)
    else $error("near full dropped");
  a_near_e_set: assert property ($rose(near_empty_flag) && quiet |-> level < $past(level))
    else $error("near empty rose without read");
  c_full: cover property ($rose(full));
  c_near_empty: cover property ($rose(near_empty_flag));
  c_slverr: cover property (pslverr);
endmodule
bind fifo_flag_top fifo_flag_checker u_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .wr_en(wr_en), .rd_en(rd_en), .full(full),
  .empty(empty), .near_full_flag(near_full_flag), .near_empty_flag(near_empty_flag), .level(level));

//--- tb/fifo_user_model.sv
// user logic at the fifo ports: raises requests, with random gaps when slow
`timescale 1ns/1ns
module fifo_user_model (
  // clock and reset
  input  wire clk_sys,
  input  wire resetn,
  // wishes from the bench
  input  wire want_wr,
  input  wire want_rd,
  input  wire slow,
  // fifo requests
  output reg  wr_en,
  output reg  rd_en
);
  // one request per port per cycle; a slow partner drops about half of them
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end else begin
      wr_en <= want_wr && !(slow && $urandom % 2);
      rd_en <= want_rd && !(slow && $urandom % 2);
    end
  end
endmodule
